// >>> tmc_pkg.sv
/*
 Package for the triple mode counter: register offsets, mode codes,
 reset values, timing constants and the carrier structs.
 Assumes a 125 MHz system clock and a 10 MHz measurement reference.
*/
package tmc_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] REG_COUNT0 = 4'h0;  // Count of counter 1
    localparam logic [3:0] REG_COUNT1 = 4'h1;  // Count of counter 2
    localparam logic [3:0] REG_COUNT2 = 4'h2;  // Count of counter 3
    localparam logic [3:0] REG_RESULT0 = 4'h4; // Latched result counter 1
    localparam logic [3:0] REG_RESULT1 = 4'h5; // Latched result counter 2
    localparam logic [3:0] REG_RESULT2 = 4'h6; // Latched result counter 3
    localparam logic [3:0] REG_MODE = 4'h8;    // Modes, 3 bits each
    localparam logic [3:0] REG_STATUS = 4'h9;  // Carry and borrow flags

    // Field positions in the mode word
    localparam int MODE_W = 3;            // Bits per mode field
    // Field positions in the status word
    localparam int STAT_CARRY_LSB = 0;    // Carry flags bits 2:0
    localparam int STAT_BORROW_LSB = 4;   // Borrow flags bits 6:4

    // Reset values
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [2:0] MODE_RST = 3'h0;

    // Reference timing
    localparam int CLK_MHZ = 125;         // System clock rate
    localparam int REF_MHZ = 10;          // Pulse-width reference rate
    localparam int REF_ACC_W = 8;         // Phase accumulator width

    // Operating modes
    typedef enum logic [2:0] {
        TMC_UPDOWN = 3'h0, // Pulse up/down
        TMC_QA_RISE = 3'h1, // Rising edges of phase A
        TMC_QB_RISE = 3'h2, // Rising edges of phase B
        TMC_QA_BOTH = 3'h3, // Both edges of phase A
        TMC_QB_BOTH = 3'h4, // Both edges of phase B
        TMC_QUAD4 = 3'h5,   // All edges, fourfold
        TMC_PWIDTH = 3'h6,  // Pulse width
        TMC_FREQ = 3'h7     // Frequency
    } tmc_mode_t;

    // Phase input pair of one counter
    typedef struct packed {
        logic phase_a_input; // First input
        logic phase_b_input; // Second input
    } tmc_phase_t;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;   // Register index
        logic [15:0] wdata; // Write data
        logic wr;           // Write strobe
        logic rd;           // Read strobe
    } tmc_req_t;
endpackage

// >>> tmc_channel.sv
/*
 One counter channel of the triple mode counter: edge detection,
 mode decode, 16-bit count, result latch and carry/borrow flags.
 Assumes inputs synchronous to the clock and a one-cycle ref tick.
*/
`timescale 1ns/100ps
module tmc_channel (
    input  wire logic              clock,     // System clock
    input  wire logic              sys_rst,   // Sync reset, active high
    input  wire tmc_pkg::tmc_mode_t mode,     // Operating mode
    input  wire tmc_pkg::tmc_phase_t phase,   // Phase inputs
    input  wire logic              five_volt, // Mode 0 variant select
    input  wire logic              ref_tick,  // 10 MHz reference tick
    input  wire logic              load,      // Preset strobe
    input  wire logic [15:0]       load_val,  // Preset value
    output logic      [15:0]       count,     // Live count
    output logic      [15:0]       result,    // Latched result
    output logic                   carry_flag, // Sticky carry
    output logic                   borrow_flag // Sticky borrow
);
    logic       prev_a;      // Phase A one cycle ago
    logic       prev_b;      // Phase B one cycle ago
    logic       a_rise;      // Phase A rising edge
    logic       a_fall;      // Phase A falling edge
    logic       b_rise;      // Phase B rising edge
    logic       b_fall;      // Phase B falling edge
    logic       step;        // Count step this cycle
    logic       up;          // Direction of the step
    logic       quad_up;     // Quadrature direction
    logic       gate;        // Measurement window open
    logic [15:0] next_count; // Count after the step
    logic       cross_up;    // Negative to positive by counting up
    logic       cross_dn;    // Positive to negative by counting down

    // Edge history
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
        end else begin
            prev_a <= phase.phase_a_input;
            prev_b <= phase.phase_b_input;
        end
    end

    assign a_rise = phase.phase_a_input & ~prev_a;
    assign a_fall = ~phase.phase_a_input & prev_a;
    assign b_rise = phase.phase_b_input & ~prev_b;
    assign b_fall = ~phase.phase_b_input & prev_b;

    // Quadrature direction: A leading B counts up
    always_comb begin
        quad_up = 1'b0;
        if (a_rise | a_fall) begin
            quad_up = phase.phase_a_input ^ phase.phase_b_input;
        end else begin
            quad_up = ~(phase.phase_a_input ^ phase.phase_b_input);
        end
    end

    // Mode decode into step and direction
    always_comb begin
        step = 1'b0;
        up   = 1'b1;
        unique case (mode)
            tmc_pkg::TMC_UPDOWN: begin
                if (five_volt) begin
                    step = a_rise;
                    up   = ~phase.phase_b_input;
                end else begin
                    // Both at once cancel, so neither wins
                    step = (b_rise & ~phase.phase_a_input) ^
                           (a_rise & ~phase.phase_b_input);
                    up   = b_rise;
                end
            end
            tmc_pkg::TMC_QA_RISE: begin
                step = a_rise;
                up   = quad_up;
            end
            tmc_pkg::TMC_QB_RISE: begin
                step = b_rise;
                up   = quad_up;
            end
            tmc_pkg::TMC_QA_BOTH: begin
                step = a_rise | a_fall;
                up   = quad_up;
            end
            tmc_pkg::TMC_QB_BOTH: begin
                step = b_rise | b_fall;
                up   = quad_up;
            end
            tmc_pkg::TMC_QUAD4: begin
                // Simultaneous edges are a glitch; skip them
                step = (a_rise | a_fall) ^ (b_rise | b_fall);
                up   = quad_up;
            end
            tmc_pkg::TMC_PWIDTH: begin
                step = gate & ref_tick;
                up   = ~phase.phase_b_input;
            end
            tmc_pkg::TMC_FREQ: begin
                step = gate & a_rise;
                up   = 1'b1;
            end
        endcase
    end

    // Measurement window for modes 6 and 7
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gate <= 1'b0;
        end else if (mode == tmc_pkg::TMC_PWIDTH) begin
            if (a_fall) begin
                gate <= 1'b1;
            end else if (a_rise) begin
                gate <= 1'b0;
            end
        end else if (mode == tmc_pkg::TMC_FREQ) begin
            if (b_fall) begin
                gate <= 1'b1;
            end else if (b_rise) begin
                gate <= 1'b0;
            end
        end else begin
            gate <= 1'b0;
        end
    end

    // Wraps modulo 2^16 by plain truncation
    assign next_count = up ? 16'(count + 16'h0001)
                           : 16'(count - 16'h0001);
    assign cross_up = step & up & count[15] & ~next_count[15];
    assign cross_dn = step & ~up & ~count[15] & next_count[15];

    // Count register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count <= tmc_pkg::COUNT_RST;
        end else if (load) begin
            count <= load_val;
        end else if (mode == tmc_pkg::TMC_FREQ && b_rise && gate) begin
            count <= tmc_pkg::COUNT_RST;
        end else if (step) begin
            count <= next_count;
        end
    end

    // Result latch for the measuring modes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            result <= tmc_pkg::COUNT_RST;
        end else if (mode == tmc_pkg::TMC_PWIDTH && a_rise && gate) begin
            result <= count;
        end else if (mode == tmc_pkg::TMC_FREQ && b_rise && gate) begin
            result <= count;
        end
    end

    // Sticky flags; a preset in the event cycle clears them, because
    // the preset value replaces the count that made the event
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            carry_flag  <= 1'b0;
            borrow_flag <= 1'b0;
        end else if (cross_up & ~load) begin
            carry_flag  <= 1'b1;
            borrow_flag <= 1'b0;
        end else if (cross_dn & ~load) begin
            borrow_flag <= 1'b1;
            carry_flag  <= 1'b0;
        end else if (load) begin
            carry_flag  <= 1'b0;
            borrow_flag <= 1'b0;
        end
    end
endmodule

// >>> tmc_top.sv
/*
 Top of the triple mode counter: three channels, the 10 MHz reference
 tick generator and the register port (read data one cycle later).
 Assumes all inputs synchronous to the 125 MHz clock; the host keeps
 counter numbers valid and holds off while it is restarting.
*/
`timescale 1ns/100ps
module tmc_top (
    input  wire logic              clock,     // 125 MHz system clock
    input  wire logic              sys_rst,   // Sync reset, active high
    input  wire tmc_pkg::tmc_req_t req,       // Register port request
    output logic      [15:0]       rdata,     // Read data, next cycle
    input  wire tmc_pkg::tmc_phase_t [2:0] phase, // Phase input pairs
    input  wire logic              five_volt, // Mode 0 variant select
    output logic      [2:0]        carry_flag, // Carry per counter
    output logic      [2:0]        borrow_flag // Borrow per counter
);
    localparam int CH = 3;                  // Number of counters

    tmc_pkg::tmc_mode_t [2:0] mode;         // Mode per counter
    logic [2:0][15:0] count;                // Live counts
    logic [2:0][15:0] result;               // Latched results
    logic [2:0]       load;                 // Preset strobes
    logic [tmc_pkg::REF_ACC_W-1:0] ref_acc; // Reference phase
    logic [tmc_pkg::REF_ACC_W:0]   ref_sum; // Accumulator sum
    logic             ref_tick;             // 10 MHz tick
    logic [15:0]      next_rdata;           // Read mux output

    // Fractional divider: 10 ticks per 125 clocks, 10 MHz on average
    assign ref_sum = {1'b0, ref_acc} +
                     (tmc_pkg::REF_ACC_W+1)'(tmc_pkg::REF_MHZ);
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ref_acc  <= '0;
            ref_tick <= 1'b0;
        end else if (ref_sum >= (tmc_pkg::REF_ACC_W+1)'(tmc_pkg::CLK_MHZ)) begin
            ref_acc  <= tmc_pkg::REF_ACC_W'(ref_sum -
                        (tmc_pkg::REF_ACC_W+1)'(tmc_pkg::CLK_MHZ));
            ref_tick <= 1'b1;
        end else begin
            ref_acc  <= ref_sum[tmc_pkg::REF_ACC_W-1:0];
            ref_tick <= 1'b0;
        end
    end

    // Mode register, one field per counter
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < CH; i++) begin
                mode[i] <= tmc_pkg::tmc_mode_t'(tmc_pkg::MODE_RST);
            end
        end else if (req.wr && req.addr == tmc_pkg::REG_MODE) begin
            for (int i = 0; i < CH; i++) begin
                mode[i] <= tmc_pkg::tmc_mode_t'(
                    req.wdata[i*tmc_pkg::MODE_W +: tmc_pkg::MODE_W]);
            end
        end
    end

    // Preset decode; writes to a count offset load that counter
    always_comb begin
        load = '0;
        if (req.wr) begin
            unique case (req.addr)
                tmc_pkg::REG_COUNT0: load = 3'h1;
                tmc_pkg::REG_COUNT1: load = 3'h2;
                tmc_pkg::REG_COUNT2: load = 3'h4;
                default:             load = 3'h0;
            endcase
        end
    end

    // Three identical channels
    for (genvar g = 0; g < CH; g++) begin : g_ch
        tmc_channel u_ch (
            .clock       (clock),
            .sys_rst     (sys_rst),
            .mode        (mode[g]),
            .phase       (phase[g]),
            .five_volt   (five_volt),
            .ref_tick    (ref_tick),
            .load        (load[g]),
            .load_val    (req.wdata),
            .count       (count[g]),
            .result      (result[g]),
            .carry_flag  (carry_flag[g]),
            .borrow_flag (borrow_flag[g])
        );
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        next_rdata = 16'h0000;
        unique case (req.addr)
            tmc_pkg::REG_COUNT0:  next_rdata = count[0];
            tmc_pkg::REG_COUNT1:  next_rdata = count[1];
            tmc_pkg::REG_COUNT2:  next_rdata = count[2];
            tmc_pkg::REG_RESULT0: next_rdata = result[0];
            tmc_pkg::REG_RESULT1: next_rdata = result[1];
            tmc_pkg::REG_RESULT2: next_rdata = result[2];
            tmc_pkg::REG_MODE:    next_rdata = {7'h00, mode[2], mode[1],
                                                mode[0]};
            tmc_pkg::REG_STATUS:  next_rdata = {9'h000, borrow_flag,
                                                1'b0, carry_flag};
            default:              next_rdata = 16'h0000;
        endcase
    end

    // Read data stand one cycle after the strobe only
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata <= 16'h0000;
        end else if (req.rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 16'h0000;
        end
    end
endmodule

// >>> tmc_chk.sv
/*
 Checker for the triple mode counter top: register port and flags.
 Assumes it is bound to tmc_top and sees only that module's ports.
*/
`timescale 1ns/100ps
module tmc_chk (
    input wire logic                      clock,       // System clock
    input wire logic                      sys_rst,     // Sync reset
    input wire tmc_pkg::tmc_req_t         req,         // Register request
    input wire logic [15:0]               rdata,       // Read data
    input wire tmc_pkg::tmc_phase_t [2:0] phase,       // Phase pairs
    input wire logic                      five_volt,   // Variant select
    input wire logic [2:0]                carry_flag,  // Carry flags
    input wire logic [2:0]                borrow_flag  // Borrow flags
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Mode word written, then read back after one idle cycle
    sequence s_mode_wr_rd;
        req.wr && req.addr == tmc_pkg::REG_MODE ##2
        req.rd && req.addr == tmc_pkg::REG_MODE;
    endsequence

    // Preset then read of counter 1; phases quiet so no step sneaks in
    sequence s_cnt_wr_rd;
        (req.wr && req.addr == 4'h0 && phase[0].phase_a_input &&
         $stable(phase)) ##1 $stable(phase) ##1
        (req.rd && req.addr == 4'h0 && $stable(phase));
    endsequence

    a_rdata_idle: assert property (!req.rd |=> rdata == 16'h0000)
        else $error("read data not zero outside read answer");
    a_flags_excl: assert property ((carry_flag & borrow_flag) == 3'h0)
        else $error("carry and borrow both set on one counter");
    a_preset_clr: assert property (req.wr && req.addr < 4'h3 |=>
        !carry_flag[$past(req.addr[1:0])] &&
        !borrow_flag[$past(req.addr[1:0])])
        else $error("preset left a flag set");
    a_reset_zero: assert property ($fell(sys_rst) |-> rdata == 16'h0000 &&
        carry_flag == 3'h0 && borrow_flag == 3'h0)
        else $error("outputs not clear after reset");
    a_status_read: assert property (
        req.rd && req.addr == tmc_pkg::REG_STATUS |=>
        rdata == {9'h000, $past(borrow_flag), 1'b0, $past(carry_flag)})
        else $error("status word does not match flags");
    a_unmapped_rd: assert property (req.rd && req.addr == 4'h3 |=>
        rdata == 16'h0000)
        else $error("unmapped read returned data");
    a_mode_read: assert property (s_mode_wr_rd |=>
        rdata[8:0] == $past(req.wdata[8:0], 3))
        else $error("mode word not read back");
    a_preset_read: assert property (s_cnt_wr_rd |=>
        rdata == $past(req.wdata, 3))
        else $error("preset value not read back");
endmodule

bind tmc_top tmc_chk i_tmc_chk (
    .clock(clock), .sys_rst(sys_rst), .req(req), .rdata(rdata),
    .phase(phase), .five_volt(five_volt), .carry_flag(carry_flag),
    .borrow_flag(borrow_flag));

// >>> tmc_enc.sv
/*
 Encoder model driving the same phase pair into all three counters.
 Assumes the bench calls its tasks; levels change after a rising edge.
*/
`timescale 1ns/100ps
module tmc_enc (
    input  wire logic                 clock, // System clock
    output tmc_pkg::tmc_phase_t [2:0] phase  // Phase pairs to the design
);
    logic a_lvl = 1'b0; // First phase level
    logic b_lvl = 1'b0; // Second phase level

    // Same pair on every counter, so one motion tests all three
    assign phase = {3{{a_lvl, b_lvl}}};

    // New levels, held long enough to be sampled twice
    task automatic set_ab(input logic a, input logic b);
        @(posedge clock);
        a_lvl <= a;
        b_lvl <= b;
        repeat (2) @(posedge clock);
    endtask

    // One full quadrature period; A leads B when moving up
    task automatic quad(input logic up);
        logic [7:0] st;
        st = up ? 8'b10_11_01_00 : 8'b01_11_10_00;
        for (int i = 3; i >= 0; i--) begin
            set_ab(st[2*i+1], st[2*i]);
        end
    endtask
endmodule

// >>> tb.sv
/*
 Self-checking bench for the triple mode counter top.
 Assumes tmc_chk is bound in and tmc_enc drives the phase inputs.
*/
`timescale 1ns/100ps
module tb;
    logic                      clock = 1'b0;     // 125 MHz clock
    logic                      sys_rst = 1'b1;   // Sync reset
    tmc_pkg::tmc_req_t         req = '0;         // Register request
    logic [15:0]               rdata;            // Read data
    tmc_pkg::tmc_phase_t [2:0] phase;            // Phase pairs
    logic                      five_volt = 1'b1; // Mode 0 variant
    logic                      restart_inhibit_bit = 1'b1; // Host restart
    logic [2:0]                carry_flag;       // Carry flags
    logic [2:0]                borrow_flag;      // Borrow flags
    logic [15:0]               q;                // Last read value
    int                        err_count = 0;    // Mismatches
    int                        total_checks = 0; // Comparisons
    int                        cycles = 0;       // Timeout counter

    always #4 clock = ~clock;

    tmc_top i_tmc_top (.clock(clock), .sys_rst(sys_rst), .req(req),
        .rdata(rdata), .phase(phase), .five_volt(five_volt),
        .carry_flag(carry_flag), .borrow_flag(borrow_flag));
    tmc_enc i_tmc_enc (.clock(clock), .phase(phase));

    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        wait (!restart_inhibit_bit);
        @(posedge clock);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clock);
        req.wr <= 1'b0;
    endtask

    // One-cycle read strobe, data taken in the answer cycle
    task automatic rd(input logic [3:0] a);
        wait (!restart_inhibit_bit);
        @(posedge clock);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clock);
        req.rd <= 1'b0;
        #1 q = rdata;
    endtask

    // Range compare; equal bounds make an exact compare
    task automatic chk(input string n, input logic [15:0] lo,
                       input logic [15:0] hi);
        total_checks++;
        if (!(q >= lo && q <= hi) || $isunknown(q)) begin
            err_count++;
            $display("ERROR %s expected %h..%h seen %h", n, lo, hi, q);
        end
    endtask

    task automatic rdchk(input string n, input logic [3:0] a,
                         input logic [15:0] e);
        rd(a);
        chk(n, e, e);
    endtask

    task automatic give_verdict;
        $display("Checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Hang guard, far above the roughly 730 cycles the run needs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        restart_inhibit_bit <= 1'b0;
        rdchk("count", 4'h0, 16'h0000);
        rdchk("status", tmc_pkg::REG_STATUS, 16'h0000);
        rdchk("unmapped", 4'h3, 16'h0000);
        // Modes set first; stray write to a hole must not land
        wr(4'hf, 16'hffff);
        wr(tmc_pkg::REG_MODE, 16'h0159);
        rdchk("mode", tmc_pkg::REG_MODE, 16'h0159);
        // Mixed modes: 1,3,5 then 2,4,5 give 1,2,4 steps a period
        for (int c = 0; c < 2; c++) begin
            wr(tmc_pkg::REG_MODE, c ? 16'h0162 : 16'h0159);
            for (int k = 0; k < 3; k++) wr(4'(k), 16'h0000);
            i_tmc_enc.quad(1'b1);
            for (int k = 0; k < 3; k++) rdchk("up", 4'(k), 16'(1 << k));
            i_tmc_enc.quad(1'b0);
            for (int k = 0; k < 3; k++) rdchk("down", 4'(k), 16'h0000);
        end
        // Mode 0, 5 V: wrap both ways through zero
        wr(tmc_pkg::REG_MODE, 16'h0000);
        i_tmc_enc.set_ab(1'b0, 1'b1);
        i_tmc_enc.set_ab(1'b1, 1'b1);
        i_tmc_enc.set_ab(1'b0, 1'b1);
        rdchk("count", 4'h0, 16'hffff);
        rdchk("status", tmc_pkg::REG_STATUS, 16'h0070);
        i_tmc_enc.set_ab(1'b0, 1'b0);
        i_tmc_enc.set_ab(1'b1, 1'b0);
        i_tmc_enc.set_ab(1'b0, 1'b0);
        rdchk("count", 4'h0, 16'h0000);
        rdchk("status", tmc_pkg::REG_STATUS, 16'h0007);
        wr(4'h0, 16'h1234);
        rdchk("status", tmc_pkg::REG_STATUS, 16'h0006);
        // Mode 0, 24 V: B pulse up, A pulse down
        @(posedge clock);
        five_volt <= 1'b0;
        i_tmc_enc.set_ab(1'b0, 1'b1);
        i_tmc_enc.set_ab(1'b0, 1'b0);
        rdchk("count", 4'h1, 16'h0001);
        i_tmc_enc.set_ab(1'b1, 1'b0);
        i_tmc_enc.set_ab(1'b0, 1'b0);
        rdchk("count", 4'h1, 16'h0000);
        // Pulse width: 253 clocks low is 20 reference ticks
        wr(tmc_pkg::REG_MODE, 16'h01b6);
        for (int d = 0; d < 2; d++) begin
            i_tmc_enc.set_ab(1'b1, 1'(d));
            wr(4'h0, 16'h0000);
            rdchk("count", 4'h0, 16'h0000);
            i_tmc_enc.set_ab(1'b0, 1'(d));
            repeat (250) @(posedge clock);
            i_tmc_enc.set_ab(1'b1, 1'(d));
            rd(tmc_pkg::REG_RESULT0);
            if (d == 0) chk("width", 16'd19, 16'd21);
            else chk("width", 16'hffeb, 16'hffed);
        end
        // Frequency: five A rises inside the B-low window
        wr(tmc_pkg::REG_MODE, 16'h01ff);
        // Width test leaves a stale count; start the window from zero
        wr(4'h1, 16'h0000);
        i_tmc_enc.set_ab(1'b0, 1'b1);
        i_tmc_enc.set_ab(1'b0, 1'b0);
        for (int k = 0; k < 5; k++) begin
            i_tmc_enc.set_ab(1'b1, 1'b0);
            i_tmc_enc.set_ab(1'b0, 1'b0);
        end
        i_tmc_enc.set_ab(1'b0, 1'b1);
        rdchk("result", tmc_pkg::REG_RESULT1, 16'h0005);
        rdchk("count", 4'h1, 16'h0000);
        give_verdict();
    end
endmodule
